//--- rtl/motor_cfg_pkg.sv
package motor_cfg_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] DRIVE_SPEED_CONFIG_ADDR = 8'h95;
  localparam logic [7:0] INDUCTIVE_SENSE_CONFIG_ADDR = 8'h96;
  localparam logic [15:0] DRIVE_SPEED_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] INDUCTIVE_SENSE_CONFIG_RESET = 16'h0000;
  // Bit 7 of the sense register is reserved and never stored
  localparam logic [15:0] INDUCTIVE_SENSE_CONFIG_WMASK = 16'hff7f;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  // ==========================================
  // Field positions, drive_speed_config
  localparam int SPEED_SOURCE_BIT = 15;
  localparam int OUTPUT_FREQ_BIT = 14;
  localparam int LOCK_WIN_HI = 13;
  localparam int LOCK_WIN_LO = 12;
  localparam int IND_GUARD_BIT = 11;
  localparam int MECH_GUARD_BIT = 10;
  localparam int MECH_CLAMP_BIT = 9;
  localparam int RELEASE_BIT = 8;
  localparam int LOOP_INHIBIT_BIT = 7;
  localparam int RAMP_HI = 6;
  localparam int RAMP_LO = 4;
  localparam int DUTY_POLICY_HI = 3;
  localparam int DUTY_POLICY_LO = 2;
  localparam int EDGE_RATE_HI = 1;
  localparam int EDGE_RATE_LO = 0;

  // ==========================================
  // Field positions, inductive_sense_config
  localparam int ADV_ANGLE_HI = 15;
  localparam int ADV_ANGLE_LO = 14;
  localparam int CUR_THR_HI = 13;
  localparam int CUR_THR_LO = 10;
  localparam int SENSE_CLK_HI = 9;
  localparam int SENSE_CLK_LO = 8;
  localparam int CTRL_CONST_HI = 6;
  localparam int CTRL_CONST_LO = 5;
  localparam int GAP_TIME_HI = 4;
  localparam int GAP_TIME_LO = 0;

  // ==========================================
  // Decoded values
  // Upper lock bound in halves of nominal, lower bound in quarters
  // Twice nominal in quarters would not fit the three-bit field
  localparam logic [2:0] LOCK_UPPER_3_2 = 3'h3;
  localparam logic [2:0] LOCK_UPPER_2 = 3'h4;
  localparam logic [2:0] LOCK_LOWER_3_4 = 3'h3;
  localparam logic [2:0] LOCK_LOWER_1_2 = 3'h2;
  localparam logic [7:0] ADVANCE_STEP_DEG = 8'h1e;
  localparam logic [4:0] SENSE_OFF_CODE = 5'h00;
  localparam logic [4:0] SENSE_MIN_CODE = 5'h01;
  localparam logic [4:0] SENSE_MIN_0P2A = 5'h02;
  // Sense measurement resolution in units of 10 ns
  localparam logic [8:0] SENSE_RES_0 = 9'h100;
  localparam logic [8:0] SENSE_RES_1 = 9'h080;
  localparam logic [8:0] SENSE_RES_2 = 9'h040;
  localparam logic [8:0] SENSE_RES_3 = 9'h020;

  // ==========================================
  // Duty in units of 0.1 percent
  localparam int DUTY_W = 10;
  localparam logic [9:0] DUTY_FULL = 10'h3e8;
  localparam logic [9:0] DUTY_CUTOFF = 10'h00f;
  localparam logic [9:0] DUTY_FLOOR_5 = 10'h032;
  localparam logic [9:0] DUTY_FLOOR_10 = 10'h064;
  localparam logic [9:0] DUTY_ZERO = 10'h000;

  // ==========================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int PWM_LOW_HZ = 25000;
  localparam int PWM_HIGH_HZ = 50000;
  localparam int PWM_LOW_CYC = CLK_HZ / PWM_LOW_HZ;
  localparam int PWM_HIGH_CYC = CLK_HZ / PWM_HIGH_HZ;
  localparam int GAP_TIME_NS = 40;
  localparam int CLK_NS = 40;
  localparam int GAP_UNIT_CYC = (GAP_TIME_NS + CLK_NS - 1) / CLK_NS;
  // Ramp rates in thousandths of supply per second, one duty step each
  localparam int RAMP_RATE_1 = 48000;
  localparam int RAMP_RATE_2 = 48000;
  localparam int RAMP_RATE_3 = 770;
  localparam int RAMP_RATE_4 = 370;
  localparam int RAMP_RATE_5 = 190;
  localparam int RAMP_RATE_6 = 91;
  localparam int RAMP_RATE_7 = 45;
  localparam int RAMP_CNT_W = 20;

  typedef enum logic [1:0] {
    RAMP_HOLD = 2'b00,
    RAMP_UP = 2'b01,
    RAMP_DOWN = 2'b10
  } ramp_dir_e;
endpackage

//--- rtl/duty_ramp_limiter.sv
`timescale 1ns/10ps
module duty_ramp_limiter #(
  parameter int W = 10,
  parameter int CW = 20
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [W-1:0] target_in,
  input wire logic immediate_in,
  input wire logic [CW-1:0] interval_in,
  output logic [W-1:0] duty_out
);
  logic [CW-1:0] tick_cnt_ff;
  logic step_en;
  motor_cfg_pkg::ramp_dir_e dir;

  // ==========================================
  // Step enable divider
  assign step_en = (tick_cnt_ff >= interval_in - CW'(1));

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_ff <= '0;
    end else if (step_en || immediate_in) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + CW'(1);
    end
  end

  always_comb begin
    if (target_in > duty_out) begin
      dir = motor_cfg_pkg::RAMP_UP;
    end else if (target_in < duty_out) begin
      dir = motor_cfg_pkg::RAMP_DOWN;
    end else begin
      dir = motor_cfg_pkg::RAMP_HOLD;
    end
  end

  // ==========================================
  // Output duty, one step per enable
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      duty_out <= '0;
    end else if (immediate_in) begin
      duty_out <= target_in;
    end else if (step_en) begin
      case (dir)
        motor_cfg_pkg::RAMP_UP: duty_out <= duty_out + W'(1);
        motor_cfg_pkg::RAMP_DOWN: duty_out <= duty_out - W'(1);
        default: duty_out <= duty_out;
      endcase
    end
  end
endmodule // duty_ramp_limiter

//--- rtl/motor_drive_config_registers.sv
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module motor_drive_config_registers #(
  parameter int RAMP_CYC_1 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_1,
  parameter int RAMP_CYC_2 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_2,
  parameter int RAMP_CYC_3 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_3,
  parameter int RAMP_CYC_4 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_4,
  parameter int RAMP_CYC_5 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_5,
  parameter int RAMP_CYC_6 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_6,
  parameter int RAMP_CYC_7 = motor_cfg_pkg::CLK_HZ / motor_cfg_pkg::RAMP_RATE_7
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Engine side: duty command and loop state
  input wire logic [9:0] duty_command_in,
  input wire logic transfer_speed_reached_in,
  // Decoded drive settings
  output logic speed_source_select_out,
  output logic output_frequency_select_out,
  output logic [2:0] bemf_lock_upper_out,
  output logic [2:0] bemf_lock_lower_out,
  output logic inductive_surge_guard_en_out,
  output logic mechanical_surge_guard_en_out,
  output logic mechanical_surge_clamp_sel_out,
  output logic sense_release_behaviour_out,
  output logic closed_loop_active_out,
  output logic [2:0] closed_loop_ramp_rate_out,
  output logic [1:0] phase_edge_rate_out,
  output logic [9:0] policy_duty_out,
  output logic [9:0] applied_duty_out,
  output logic pwm_period_start_out,
  output logic pwm_high_out,
  // Decoded sense settings
  output logic [7:0] sense_advance_angle_out,
  output logic sense_enable_out,
  output logic [4:0] sense_current_threshold_out,
  output logic [1:0] sense_clock_select_out,
  output logic [8:0] sense_resolution_out,
  output logic [2:0] control_constant_out,
  output logic [5:0] driver_gap_time_out
);
  localparam int PW = 10;

  logic [15:0] drive_speed_config_ff;
  logic [15:0] inductive_sense_config_ff;
  logic [15:0] nxt_rdata;
  logic [9:0] nxt_policy_duty;
  logic [9:0] duty_floor;
  logic [19:0] ramp_interval;
  logic ramp_immediate;
  logic [9:0] pwm_cnt_ff;
  logic [9:0] pwm_period;
  logic [9:0] duty_scaled;
  logic [9:0] ramp_duty;
  logic [1:0] lock_code;
  logic [3:0] cur_code;
  logic [1:0] sense_clk_code;

  // ==========================================
  // Register writes
  // Drive register store
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drive_speed_config_ff <= motor_cfg_pkg::DRIVE_SPEED_CONFIG_RESET;
    end else if (reg_wr_in && reg_addr_in == motor_cfg_pkg::DRIVE_SPEED_CONFIG_ADDR) begin
      drive_speed_config_ff <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      inductive_sense_config_ff <= motor_cfg_pkg::INDUCTIVE_SENSE_CONFIG_RESET;
    end else if (reg_wr_in && reg_addr_in == motor_cfg_pkg::INDUCTIVE_SENSE_CONFIG_ADDR) begin
      inductive_sense_config_ff <= reg_wdata_in & motor_cfg_pkg::INDUCTIVE_SENSE_CONFIG_WMASK;
    end
  end

  // ==========================================
  // Register reads
  // Read back stored fields
  always_comb begin
    if (!reg_rd_in) begin
      nxt_rdata = motor_cfg_pkg::READ_IDLE;
    end else if (reg_addr_in == motor_cfg_pkg::DRIVE_SPEED_CONFIG_ADDR) begin
      nxt_rdata = drive_speed_config_ff;
    end else if (reg_addr_in == motor_cfg_pkg::INDUCTIVE_SENSE_CONFIG_ADDR) begin
      nxt_rdata = inductive_sense_config_ff;
    end else begin
      nxt_rdata = motor_cfg_pkg::READ_IDLE;
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= motor_cfg_pkg::READ_IDLE;
    end else begin
      reg_rdata_out <= nxt_rdata;
    end
  end

  // ==========================================
  // Drive field decode
  // Speed source select
  assign speed_source_select_out = drive_speed_config_ff[motor_cfg_pkg::SPEED_SOURCE_BIT];
  assign output_frequency_select_out = drive_speed_config_ff[motor_cfg_pkg::OUTPUT_FREQ_BIT];
  assign inductive_surge_guard_en_out = drive_speed_config_ff[motor_cfg_pkg::IND_GUARD_BIT];
  assign mechanical_surge_guard_en_out = drive_speed_config_ff[motor_cfg_pkg::MECH_GUARD_BIT];
  assign mechanical_surge_clamp_sel_out = drive_speed_config_ff[motor_cfg_pkg::MECH_CLAMP_BIT];
  assign sense_release_behaviour_out = drive_speed_config_ff[motor_cfg_pkg::RELEASE_BIT];
  assign closed_loop_ramp_rate_out = drive_speed_config_ff[motor_cfg_pkg::RAMP_HI:motor_cfg_pkg::RAMP_LO];
  assign phase_edge_rate_out = drive_speed_config_ff[motor_cfg_pkg::EDGE_RATE_HI:motor_cfg_pkg::EDGE_RATE_LO];

  assign lock_code = drive_speed_config_ff[motor_cfg_pkg::LOCK_WIN_HI:motor_cfg_pkg::LOCK_WIN_LO];

  always_comb begin
    if (lock_code[0]) begin
      bemf_lock_upper_out = motor_cfg_pkg::LOCK_UPPER_2;
    end else begin
      bemf_lock_upper_out = motor_cfg_pkg::LOCK_UPPER_3_2;
    end
    if (lock_code[1]) begin
      bemf_lock_lower_out = motor_cfg_pkg::LOCK_LOWER_1_2;
    end else begin
      bemf_lock_lower_out = motor_cfg_pkg::LOCK_LOWER_3_4;
    end
  end

  // ==========================================
  // Loop transfer
  // Closed loop only when allowed
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      closed_loop_active_out <= 1'b0;
    end else if (drive_speed_config_ff[motor_cfg_pkg::LOOP_INHIBIT_BIT]) begin
      closed_loop_active_out <= 1'b0;
    end else if (transfer_speed_reached_in) begin
      closed_loop_active_out <= 1'b1;
    end
  end

  // ==========================================
  // Minimum duty policy
  // Floor and cutoff handling
  always_comb begin
    if (drive_speed_config_ff[motor_cfg_pkg::DUTY_POLICY_LO]) begin
      duty_floor = motor_cfg_pkg::DUTY_FLOOR_10;
    end else begin
      duty_floor = motor_cfg_pkg::DUTY_FLOOR_5;
    end
    if (duty_command_in < motor_cfg_pkg::DUTY_CUTOFF) begin
      if (drive_speed_config_ff[motor_cfg_pkg::DUTY_POLICY_HI]) begin
        nxt_policy_duty = motor_cfg_pkg::DUTY_FULL;
      end else begin
        nxt_policy_duty = motor_cfg_pkg::DUTY_ZERO;
      end
    end else if (duty_command_in < duty_floor) begin
      nxt_policy_duty = duty_floor;
    end else if (duty_command_in > motor_cfg_pkg::DUTY_FULL) begin
      nxt_policy_duty = motor_cfg_pkg::DUTY_FULL;
    end else begin
      nxt_policy_duty = duty_command_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      policy_duty_out <= motor_cfg_pkg::DUTY_ZERO;
    end else begin
      policy_duty_out <= nxt_policy_duty;
    end
  end

  // ==========================================
  // Closed-loop ramp
  // Ramp interval select
  always_comb begin
    ramp_immediate = 1'b0;
    case (closed_loop_ramp_rate_out)
      3'h1: ramp_interval = 20'(RAMP_CYC_1);
      3'h2: ramp_interval = 20'(RAMP_CYC_2);
      3'h3: ramp_interval = 20'(RAMP_CYC_3);
      3'h4: ramp_interval = 20'(RAMP_CYC_4);
      3'h5: ramp_interval = 20'(RAMP_CYC_5);
      3'h6: ramp_interval = 20'(RAMP_CYC_6);
      3'h7: ramp_interval = 20'(RAMP_CYC_7);
      default: begin
        ramp_interval = 20'(RAMP_CYC_1);
        ramp_immediate = 1'b1;
      end
    endcase
    // Open loop follows the command without limiting
    if (!closed_loop_active_out) begin
      ramp_immediate = 1'b1;
    end
  end

  duty_ramp_limiter #(
    .W(motor_cfg_pkg::DUTY_W),
    .CW(motor_cfg_pkg::RAMP_CNT_W)
  ) u_ramp (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .target_in(policy_duty_out),
    .immediate_in(ramp_immediate),
    .interval_in(ramp_interval),
    .duty_out(ramp_duty)
  );

  assign applied_duty_out = ramp_duty;

  // ==========================================
  // PWM carrier
  // Carrier period from frequency select
  always_comb begin
    if (output_frequency_select_out) begin
      pwm_period = PW'(motor_cfg_pkg::PWM_HIGH_CYC);
      duty_scaled = {1'b0, ramp_duty[9:1]};
    end else begin
      pwm_period = PW'(motor_cfg_pkg::PWM_LOW_CYC);
      duty_scaled = ramp_duty;
    end
  end

  // A frequency change mid-period does not restart the carrier; the count wraps at the new period end, or at once if past it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwm_cnt_ff <= '0;
    end else if (pwm_cnt_ff >= pwm_period - PW'(1)) begin
      pwm_cnt_ff <= '0;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + PW'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwm_period_start_out <= 1'b0;
      pwm_high_out <= 1'b0;
    end else begin
      pwm_period_start_out <= (pwm_cnt_ff == '0);
      pwm_high_out <= (pwm_cnt_ff < duty_scaled);
    end
  end

  // ==========================================
  // Sense field decode
  // Advance angle in degrees
  assign sense_advance_angle_out = motor_cfg_pkg::ADVANCE_STEP_DEG *
    (8'(inductive_sense_config_ff[motor_cfg_pkg::ADV_ANGLE_HI:motor_cfg_pkg::ADV_ANGLE_LO]) + 8'h01);

  assign cur_code = inductive_sense_config_ff[motor_cfg_pkg::CUR_THR_HI:motor_cfg_pkg::CUR_THR_LO];
  assign sense_enable_out = (5'(cur_code) != motor_cfg_pkg::SENSE_OFF_CODE);

  always_comb begin
    if (5'(cur_code) == motor_cfg_pkg::SENSE_OFF_CODE) begin
      sense_current_threshold_out = 5'h00;
    end else if (5'(cur_code) == motor_cfg_pkg::SENSE_MIN_CODE) begin
      sense_current_threshold_out = motor_cfg_pkg::SENSE_MIN_0P2A;
    end else begin
      sense_current_threshold_out = 5'(cur_code) + 5'h01;
    end
  end

  assign sense_clk_code = inductive_sense_config_ff[motor_cfg_pkg::SENSE_CLK_HI:motor_cfg_pkg::SENSE_CLK_LO];
  assign sense_clock_select_out = sense_clk_code;

  always_comb begin
    case (sense_clk_code)
      2'h0: sense_resolution_out = motor_cfg_pkg::SENSE_RES_0;
      2'h1: sense_resolution_out = motor_cfg_pkg::SENSE_RES_1;
      2'h2: sense_resolution_out = motor_cfg_pkg::SENSE_RES_2;
      default: sense_resolution_out = motor_cfg_pkg::SENSE_RES_3;
    endcase
  end

  // Constant in quarters, gap in cycles
  assign control_constant_out =
    3'(inductive_sense_config_ff[motor_cfg_pkg::CTRL_CONST_HI:motor_cfg_pkg::CTRL_CONST_LO]) + 3'h1;
  assign driver_gap_time_out = 6'(motor_cfg_pkg::GAP_UNIT_CYC) *
    (6'(inductive_sense_config_ff[motor_cfg_pkg::GAP_TIME_HI:motor_cfg_pkg::GAP_TIME_LO]) + 6'h01);
endmodule // motor_drive_config_registers

//--- verif/motor_cfg_checker_sva.sv
`timescale 1ns/10ps
module motor_cfg_checker (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [9:0] duty_command_in,
  input wire logic transfer_speed_reached_in,
  input wire logic speed_source_select_out,
  input wire logic output_frequency_select_out,
  input wire logic inductive_surge_guard_en_out,
  input wire logic mechanical_surge_guard_en_out,
  input wire logic mechanical_surge_clamp_sel_out,
  input wire logic sense_release_behaviour_out,
  input wire logic closed_loop_active_out,
  input wire logic [2:0] closed_loop_ramp_rate_out,
  input wire logic [1:0] phase_edge_rate_out,
  input wire logic [9:0] policy_duty_out,
  input wire logic pwm_period_start_out,
  input wire logic sense_enable_out,
  input wire logic [4:0] sense_current_threshold_out,
  input wire logic [1:0] sense_clock_select_out,
  input wire logic [5:0] driver_gap_time_out
);
  // ====
  // Register port, decode, duty policy, loop transfer and carrier
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic wr_drv;
  logic wr_sns;
  assign wr_drv = reg_wr_in && reg_addr_in == 8'h95;
  assign wr_sns = reg_wr_in && reg_addr_in == 8'h96;

  property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_drv_mode; wr_drv |=> {speed_source_select_out, output_frequency_select_out} == $past(reg_wdata_in[15:14]);
  endproperty
  a_drv_mode: assert property (p_drv_mode) else $error("speed source or frequency wrong");
  property p_surge; wr_drv |=> {inductive_surge_guard_en_out, mechanical_surge_guard_en_out,
    mechanical_surge_clamp_sel_out, sense_release_behaviour_out} == $past(reg_wdata_in[11:8]); endproperty
  a_surge: assert property (p_surge) else $error("surge or release bits wrong");
  property p_ramp_edge; wr_drv |=> closed_loop_ramp_rate_out == $past(reg_wdata_in[6:4])
    && phase_edge_rate_out == $past(reg_wdata_in[1:0]); endproperty
  a_ramp_edge: assert property (p_ramp_edge) else $error("ramp or edge rate wrong");
  property p_inhibit; wr_drv && reg_wdata_in[7] |=> ##1 !closed_loop_active_out; endproperty
  a_inhibit: assert property (p_inhibit) else $error("closed loop not inhibited");
  property p_enter; $rose(closed_loop_active_out) |-> $past(transfer_speed_reached_in); endproperty
  a_enter: assert property (p_enter) else $error("closed loop entered without transfer speed");
  property p_reserved; reg_rd_in && reg_addr_in == 8'h96 |=> !reg_rdata_out[7]; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit reads one");
  property p_unmapped; reg_rd_in && reg_addr_in != 8'h95 && reg_addr_in != 8'h96 |=> reg_rdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cutoff; duty_command_in < 10'h00f |=> policy_duty_out == 10'h000 || policy_duty_out == 10'h3e8;
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("low command not cut off");
  property p_linear; duty_command_in >= 10'h064 && duty_command_in <= 10'h3e8 |=>
    policy_duty_out == $past(duty_command_in); endproperty
  a_linear: assert property (p_linear) else $error("linear duty not followed");
  property p_sense; wr_sns |=> sense_clock_select_out == $past(reg_wdata_in[9:8])
    && driver_gap_time_out == 6'h01 + {1'b0, $past(reg_wdata_in[4:0])}; endproperty
  a_sense: assert property (p_sense) else $error("sense clock or gap time wrong");
  property p_enable; sense_enable_out == (sense_current_threshold_out != 5'h00); endproperty
  a_enable: assert property (p_enable) else $error("sense enable disagrees with threshold");
  property p_pulse; pwm_period_start_out |=> !pwm_period_start_out [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("period pulse too long or too close");
  c_closed: cover property ($rose(closed_loop_active_out));
  c_unmapped: cover property (reg_rd_in && reg_addr_in == 8'h97);
  c_fast: cover property (pwm_period_start_out && output_frequency_select_out);
endmodule // motor_cfg_checker

bind motor_drive_config_registers motor_cfg_checker chk (.*);

//--- verif/motor_drive_config_registers_tb.sv
`timescale 1ns/10ps
module motor_drive_config_registers_tb;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [9:0] duty_command_in = 10'h000;
  logic transfer_speed_reached_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic speed_source_select_out, output_frequency_select_out, inductive_surge_guard_en_out, sense_enable_out;
  logic mechanical_surge_guard_en_out, mechanical_surge_clamp_sel_out, sense_release_behaviour_out;
  logic closed_loop_active_out, pwm_period_start_out, pwm_high_out;
  logic [2:0] bemf_lock_upper_out, bemf_lock_lower_out, closed_loop_ramp_rate_out, control_constant_out;
  logic [1:0] phase_edge_rate_out, sense_clock_select_out;
  logic [9:0] policy_duty_out, applied_duty_out;
  logic [7:0] sense_advance_angle_out;
  logic [4:0] sense_current_threshold_out;
  logic [8:0] sense_resolution_out;
  logic [5:0] driver_gap_time_out;
  int mismatches = 0;
  int comparisons = 0;
  int cnt;
  int hi;

  always #20 ref_clk_in = ~ref_clk_in;

  // Short ramp steps keep the closed-loop run brief; codes 6 and 7 keep their defaults
  motor_drive_config_registers #(.RAMP_CYC_1(4), .RAMP_CYC_2(4), .RAMP_CYC_3(6), .RAMP_CYC_4(8),
    .RAMP_CYC_5(10)) DUT (
    .ref_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .duty_command_in, .transfer_speed_reached_in, .speed_source_select_out, .output_frequency_select_out,
    .bemf_lock_upper_out, .bemf_lock_lower_out, .inductive_surge_guard_en_out, .mechanical_surge_guard_en_out,
    .mechanical_surge_clamp_sel_out, .sense_release_behaviour_out, .closed_loop_active_out,
    .closed_loop_ramp_rate_out, .phase_edge_rate_out, .policy_duty_out, .applied_duty_out,
    .pwm_period_start_out, .pwm_high_out, .sense_advance_angle_out, .sense_enable_out,
    .sense_current_threshold_out, .sense_clock_select_out, .sense_resolution_out, .control_constant_out,
    .driver_gap_time_out);

  // ====
  // Tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_out);
  endtask

  task automatic duty_chk(input logic [9:0] cmd, input logic [9:0] exp);
    @(posedge ref_clk_in);
    duty_command_in <= cmd;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("policy_duty", {6'h00, exp}, {6'h00, policy_duty_out});
    chk("applied_duty", {6'h00, exp}, {6'h00, applied_duty_out});
  endtask

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ====
  // Sequence
  initial begin
    logic [15:0] d;
    logic [3:0] c;
    repeat (4) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    rd(8'h95, 16'h0000, "drive_reset");
    rd(8'h96, 16'h0000, "sense_reset");
    // walking one over every drive field
    for (int i = 0; i < 16; i++) begin
      d = 16'h0001 << i;
      wr(8'h95, d);
      chk("drive_fields", {5'h00, d[15:14], d[11:8], d[6:4], d[1:0]}, {5'h00, speed_source_select_out,
        output_frequency_select_out, inductive_surge_guard_en_out, mechanical_surge_guard_en_out,
        mechanical_surge_clamp_sel_out, sense_release_behaviour_out, closed_loop_ramp_rate_out,
        phase_edge_rate_out});
      chk("lock_window", {10'h000, d[12] ? 3'h4 : 3'h3, d[13] ? 3'h2 : 3'h3},
        {10'h000, bemf_lock_upper_out, bemf_lock_lower_out});
      rd(8'h95, d, "drive_readback");
    end
    // every sense code, reserved bit always written
    for (int i = 0; i < 32; i++) begin
      d = {i[1:0], i[3:0], i[1:0], 1'b1, i[1:0], i[4:0]};
      c = i[3:0];
      wr(8'h96, d);
      rd(8'h96, d & 16'hff7f, "sense_readback");
      chk("sense_angle", {8'h00, 8'h1e * (8'h01 + {6'h00, i[1:0]})}, {8'h00, sense_advance_angle_out});
      chk("sense_thr", {10'h000, c != 4'h0, (c == 4'h0) ? 5'h00 : (c == 4'h1) ? 5'h02 : {1'b0, c} + 5'h01},
        {10'h000, sense_enable_out, sense_current_threshold_out});
      chk("sense_res", {5'h00, 9'h100 >> i[1:0], i[1:0]},
        {5'h00, sense_resolution_out, sense_clock_select_out});
      chk("ctrl_gap", {7'h00, 3'h1 + {1'b0, i[1:0]}, 6'h01 + {1'b0, i[4:0]}},
        {7'h00, control_constant_out, driver_gap_time_out});
    end
    wr(8'h97, 16'hffff);
    wr(8'h94, 16'hffff);
    rd(8'h97, 16'h0000, "unmapped_read");
    rd(8'h95, 16'h8000, "drive_kept");
    rd(8'h96, 16'hff7f, "sense_kept");
    // every policy code, open loop follows at once
    for (int p = 0; p < 4; p++) begin
      wr(8'h95, {12'h008, p[1:0], 2'b00});
      duty_chk(10'h00a, p[1] ? 10'h3e8 : 10'h000);
      duty_chk(10'h00f, p[0] ? 10'h064 : 10'h032);
      duty_chk(10'h046, p[0] ? 10'h064 : 10'h046);
      duty_chk(10'h3ff, 10'h3e8);
    end
    @(posedge ref_clk_in);
    transfer_speed_reached_in <= 1'b1;
    duty_chk(10'h258, 10'h258);
    chk("loop_inhibited", 16'h0000, {15'h0000, closed_loop_active_out});
    wr(8'h95, 16'h0010);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("loop_entered", 16'h0001, {15'h0000, closed_loop_active_out});
    @(posedge ref_clk_in);
    duty_command_in <= 10'h262;
    repeat (12) @(posedge ref_clk_in);
    #1;
    comparisons++;
    if ((applied_duty_out > 10'h258 && applied_duty_out < 10'h262) !== 1'b1) begin
      mismatches++;
      $display("[FAIL] ramp_partial expected between 258 and 262 seen %h", applied_duty_out);
    end
    @(posedge ref_clk_in);
    transfer_speed_reached_in <= 1'b0;
    repeat (60) @(posedge ref_clk_in);
    #1;
    chk("ramp_done", 16'h0262, {6'h00, applied_duty_out});
    chk("loop_sticky", 16'h0001, {15'h0000, closed_loop_active_out});
    wr(8'h95, 16'h0000);
    duty_chk(10'h0c8, 10'h0c8);
    // carrier period and high time at both rates
    for (int f = 0; f < 2; f++) begin
      wr(8'h95, {1'b0, f[0], 14'h0080});
      // Loop state follows the inhibit bit one cycle after the write
      @(posedge ref_clk_in);
      #1;
      chk("loop_left", 16'h0000, {15'h0000, closed_loop_active_out});
      repeat (2) repeat (1100) begin
        @(posedge ref_clk_in);
        #1;
        if (pwm_period_start_out === 1'b1) break;
      end
      cnt = 0;
      hi = 0;
      do begin
        @(posedge ref_clk_in);
        #1;
        cnt++;
        hi += int'(pwm_high_out === 1'b1);
      end while (pwm_period_start_out !== 1'b1 && cnt < 1100);
      chk("pwm_period", f ? 16'h01f4 : 16'h03e8, 16'(cnt));
      chk("pwm_high", f ? 16'h0064 : 16'h00c8, 16'(hi));
    end
    stop_test();
  end

  // Whole sequence needs under 10k cycles
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    mismatches++;
    stop_test();
  end
endmodule // motor_drive_config_registers_tb
